// ### logic/jt_bsr.sv
// Boundary scan register: capture, shift and falling-edge update stages.
// Assumes controls come from the test controller on the same test clock.
`timescale 1ns/1ps
module jt_bsr #(
    parameter int W = 8
) (
    // Test clock and reset
    input  wire logic         i_tck,
    input  wire logic         i_trst_n,
    // Scan controls
    input  wire logic         i_capture,
    input  wire logic         i_shift,
    input  wire logic         i_update,
    input  wire logic         i_tdi,
    input  wire logic [W-1:0] i_cap_data,
    // Scan and update outputs
    output logic              o_so,
    output logic      [W-1:0] o_upd
);
    logic [W-1:0] shift_reg;

    // Capture pad levels or shift towards the serial output
    always_ff @(posedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            shift_reg <= '0;
        else if (i_capture)
            shift_reg <= i_cap_data;
        else if (i_shift)
            shift_reg <= {i_tdi, shift_reg[W-1:1]};
    end

    // Update latch moves on the falling edge
    always_ff @(negedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            o_upd <= '0;
        else if (i_update)
            o_upd <= shift_reg;
    end

    assign o_so = shift_reg[0];
endmodule

// ### logic/jt_pkg.sv
// Shared constants, types and decode for the boundary-scan test port.
// Assumes a test clock well below the system clock.
package jt_pkg;

    // Instruction register
    localparam int IR_W = 4;
    typedef logic [IR_W-1:0] jt_ir_t;
    localparam jt_ir_t IR_EXTEST  = 4'h0;
    localparam jt_ir_t IR_SAMPLE  = 4'h1;
    localparam jt_ir_t IR_IDCODE  = 4'h2;
    localparam jt_ir_t IR_HIGHZ   = 4'h3;
    localparam jt_ir_t IR_BYPASS  = 4'hf;
    localparam jt_ir_t IR_CAPTURE = 4'h1;   // Low two bits fixed at 01

    // Identification register layout
    localparam int ID_W       = 32;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PRT_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam int TMS_RESET_EDGES = 5;     // TMS-high edges that force reset

    // Controller states, Gray codes along the scan paths
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EXIT1_DR = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EXIT2_DR = 4'h4,
        ST_UPD_DR   = 4'hc,
        ST_SEL_IR   = 4'hd,
        ST_CAP_IR   = 4'hf,
        ST_SHIFT_IR = 4'he,
        ST_EXIT1_IR = 4'ha,
        ST_PAUSE_IR = 4'hb,
        ST_EXIT2_IR = 4'h9,
        ST_UPD_IR   = 4'h8
    } jt_state_e;

    // Data register in the serial path
    typedef enum logic [1:0] {
        DR_BYPASS = 2'h0,
        DR_BSR    = 2'h1,
        DR_IDENT  = 2'h2
    } jt_dr_e;

    // Test-mode levels handed to the system clock domain
    typedef struct packed {
        logic tap_reset;
        logic extest;
        logic highz;
    } jt_ctrl_s;

    // Instruction to data register; unknown codes pick bypass
    function automatic jt_dr_e jt_dr_sel(input jt_ir_t ir);
        if (ir == IR_EXTEST || ir == IR_SAMPLE)
            return DR_BSR;
        else if (ir == IR_IDCODE)
            return DR_IDENT;
        else
            return DR_BYPASS;
    endfunction

endpackage

// ### logic/jt_sync.sv
// Two-stage level synchroniser for a bus of independent levels.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/1ps
module jt_sync #(
    parameter int W = 1
) (
    // Destination clock and data
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge i_clk)
    begin
        meta_reg <= i_async;
        o_sync   <= meta_reg;
    end
endmodule

// ### logic/jt_tap.sv
// Test access port: controller, instruction and data registers, pad control.
// Assumes the test clock runs far slower than i_ref_clk; pads are functional
// whenever the controller sits in Test-Logic-Reset.
// Functional notes
// R1: Four test inputs: clock, mode select, data in, optional reset; one output.
// R2: State changes on rising test clock, next state from sampled mode select.
// R3: Five rising edges with mode select high reach Test-Logic-Reset.
// R4: No self reset at power-up; only reset pin or mode-select sequence.
// R5: Controller must reset the port before normal memory use.
// R6: Test logic overrides memory function while port is out of reset; here it takes the pads only under extest or high-z.
// R7: In Test-Logic-Reset all test logic disabled, device functional.
// R8: Run-Test-Idle does nothing unless instruction needs it.
// R9: Select states branch to data path, instruction path or reset.
// R10: Capture-IR loads fixed pattern, low two bits 01.
// R11: Shift-IR shifts instruction bits from data in towards data out.
// R12: Exit1-IR picks Pause or Update; Pause keeps shifted bits.
// R13: Update-IR latches instruction on falling edge, becomes active.
// R14: Instruction register is four bits, sixteen codes.
// R15: Instruction low bits sit nearest the output, leave first.
// R16: Capture-DR loads the selected data register on rising edge.
// R17: Data-path states mirror instruction-path states on selected register.
// R18: Bypass, boundary and identification registers in parallel, instruction picks.
// R19: Bypass stage cleared to zero in Capture-DR when selected.
// R20: Bypass shifting never alters functional behaviour.
// R21: Codes 0,1,2,3,F decode to extest, sample, idcode, high-z, bypass.
// R22: Identification: 32 bits, version, part, maker, bit 0 one.
// R23: High-z instruction disables all outputs and selects bypass.
// R24: Full sixteen-state transition graph of the standard.
// R25: Data out changes on falling edge, driven only in shift states.
`timescale 1ns/1ps
module jt_tap
    import jt_pkg::*;
#(
    parameter int          PADS     = 8,
    parameter logic [3:0]  ID_VER   = 4'h1,      // Arbitrary value
    parameter logic [15:0] ID_PART  = 16'h1234,  // Arbitrary value
    parameter logic [10:0] ID_MFR   = 11'h2a5    // Arbitrary value
) (
    // Test port pins
    input  wire logic            i_tck,    // R1
    input  wire logic            i_tms,
    input  wire logic            i_tdi,
    input  wire logic            i_trst_n,
    output logic                 o_tdo,
    output logic                 o_tdo_oe,
    // System clock and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_reset,
    // Functional pads
    input  wire logic [PADS-1:0] i_core_out,
    input  wire logic [PADS-1:0] i_pad_in,
    output logic      [PADS-1:0] o_pad_out,
    output logic                 o_pad_oe,
    output logic                 o_test_active
);
    import jt_pkg::*;

    localparam logic [ID_W-1:0] ID_VALUE = (ID_W'(ID_VER) << ID_VER_LSB)
        | (ID_W'(ID_PART) << ID_PRT_LSB) | (ID_W'(ID_MFR) << ID_MFR_LSB)
        | ID_W'(1);

    jt_state_e        state_reg;
    jt_state_e        state_next;
    jt_ir_t           ir_shift_reg;
    jt_ir_t           ir_active_reg;
    logic             bypass_reg;
    logic [ID_W-1:0]  id_shift_reg;
    logic [PADS-1:0]  pad_in_tck;
    logic [PADS-1:0]  bsr_upd;
    logic             bsr_so;
    logic             bsr_tgl_reg;
    jt_ctrl_s         ctrl_reg;
    jt_dr_e           dr_sel;
    logic             sel_shift_bit;
    // System-domain side
    jt_ctrl_s         ctrl_ref;
    logic             tgl_ref;
    logic             tgl_seen_reg;
    logic [PADS-1:0]  bsr_word_reg;
    // Assertion helper
    logic [2:0]       ones_cnt_reg;

    assign dr_sel = jt_dr_sel(ir_active_reg); // R18 R21 R23

    // Next-state graph of the controller
    always_comb
    begin
        state_next = state_reg; // R24
        case (state_reg)
            ST_RESET:    state_next = i_tms ? ST_RESET : ST_IDLE;
            ST_IDLE:     state_next = i_tms ? ST_SEL_DR : ST_IDLE; // R8
            ST_SEL_DR:   state_next = i_tms ? ST_SEL_IR : ST_CAP_DR; // R9
            ST_CAP_DR:   state_next = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_next = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR; // R17
            ST_EXIT1_DR: state_next = i_tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_next = i_tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_next = i_tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR:   state_next = i_tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR:   state_next = i_tms ? ST_RESET : ST_CAP_IR; // R9
            ST_CAP_IR:   state_next = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_next = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_next = i_tms ? ST_UPD_IR : ST_PAUSE_IR; // R12
            ST_PAUSE_IR: state_next = i_tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_next = i_tms ? ST_UPD_IR : ST_SHIFT_IR; // R24
            ST_UPD_IR:   state_next = i_tms ? ST_SEL_DR : ST_IDLE;
            default:     state_next = ST_RESET;
        endcase
    end

    // State register; no power-up value, only the reset pin or TMS
    always_ff @(posedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            state_reg <= ST_RESET; // R4
        else
            state_reg <= state_next; // R2 R3
    end

    // Instruction shift stages, low bit leaves first
    always_ff @(posedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            ir_shift_reg <= IR_CAPTURE;
        else if (state_reg == ST_CAP_IR)
            ir_shift_reg <= IR_CAPTURE; // R10
        else if (state_reg == ST_SHIFT_IR)
            ir_shift_reg <= {i_tdi, ir_shift_reg[IR_W-1:1]}; // R11 R14 R15
    end

    // Active instruction latched on the falling edge
    always_ff @(negedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            ir_active_reg <= IR_IDCODE;
        else if (state_reg == ST_RESET)
            ir_active_reg <= IR_IDCODE; // R7
        else if (state_reg == ST_UPD_IR)
            ir_active_reg <= ir_shift_reg; // R13
    end

    // Bypass stage
    always_ff @(posedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            bypass_reg <= 1'b0;
        else if (dr_sel == DR_BYPASS && state_reg == ST_CAP_DR)
            bypass_reg <= 1'b0; // R19
        else if (dr_sel == DR_BYPASS && state_reg == ST_SHIFT_DR)
            bypass_reg <= i_tdi; // R20
    end

    // Identification register, read only
    always_ff @(posedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            id_shift_reg <= ID_VALUE;
        else if (dr_sel == DR_IDENT && state_reg == ST_CAP_DR)
            id_shift_reg <= ID_VALUE; // R16 R22
        else if (dr_sel == DR_IDENT && state_reg == ST_SHIFT_DR)
            id_shift_reg <= {i_tdi, id_shift_reg[ID_W-1:1]}; // R17
    end

    // Pad levels brought onto the test clock for capture
    jt_sync #(
        .W (PADS)
    ) u_pad_sync (
        .i_clk   (i_tck),
        .i_async (i_pad_in),
        .o_sync  (pad_in_tck)
    );

    // Boundary scan register
    jt_bsr #(
        .W (PADS)
    ) u_bsr (
        .i_tck      (i_tck),
        .i_trst_n   (i_trst_n),
        .i_capture  (dr_sel == DR_BSR && state_reg == ST_CAP_DR), // R16
        .i_shift    (dr_sel == DR_BSR && state_reg == ST_SHIFT_DR),
        .i_update   (dr_sel == DR_BSR && state_reg == ST_UPD_DR), // R17
        .i_tdi      (i_tdi),
        .i_cap_data (pad_in_tck),
        .o_so       (bsr_so),
        .o_upd      (bsr_upd)
    );

    // Toggle marks each boundary update for the system domain
    always_ff @(negedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            bsr_tgl_reg <= 1'b0;
        else if (dr_sel == DR_BSR && state_reg == ST_UPD_DR)
            bsr_tgl_reg <= ~bsr_tgl_reg;
    end

    // Serial output chosen by the path in use
    always_comb
    begin
        case (dr_sel)
            DR_BSR:   sel_shift_bit = bsr_so;
            DR_IDENT: sel_shift_bit = id_shift_reg[0];
            default:  sel_shift_bit = bypass_reg; // R23
        endcase
    end

    // Data out moves on the falling edge, driven only while shifting
    always_ff @(negedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
        begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end
        else if (state_reg == ST_SHIFT_IR)
        begin
            o_tdo    <= ir_shift_reg[0]; // R15 R25
            o_tdo_oe <= 1'b1;
        end
        else if (state_reg == ST_SHIFT_DR)
        begin
            o_tdo    <= sel_shift_bit; // R18
            o_tdo_oe <= 1'b1;
        end
        else
        begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0; // R25
        end
    end

    // Test-mode levels for the system domain
    always_ff @(posedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            ctrl_reg <= '{tap_reset: 1'b1, extest: 1'b0, highz: 1'b0};
        else
        begin
            ctrl_reg.tap_reset <= (state_next == ST_RESET); // R6 R7
            ctrl_reg.extest    <= (ir_active_reg == IR_EXTEST);
            ctrl_reg.highz     <= (ir_active_reg == IR_HIGHZ); // R23
        end
    end

    // Crossings into the system clock
    jt_sync #(
        .W ($bits(jt_ctrl_s) + 1)
    ) u_ctrl_sync (
        .i_clk   (i_ref_clk),
        .i_async ({ctrl_reg, bsr_tgl_reg}),
        .o_sync  ({ctrl_ref, tgl_ref})
    );

    // Boundary word taken once its toggle has settled
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            tgl_seen_reg <= 1'b0;
            bsr_word_reg <= '0;
        end
        else
        begin
            tgl_seen_reg <= tgl_ref;
            if (tgl_ref != tgl_seen_reg)
                bsr_word_reg <= bsr_upd;
        end
    end

    // Pad drive: test logic wins under extest or high-z while out of reset
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_pad_out     <= '0;
            o_pad_oe      <= 1'b0;
            o_test_active <= 1'b0;
        end
        else
        begin
            o_test_active <= !ctrl_ref.tap_reset; // R6
            o_pad_oe      <= ctrl_ref.tap_reset || !ctrl_ref.highz; // R23
            if (ctrl_ref.extest && !ctrl_ref.tap_reset)
                o_pad_out <= bsr_word_reg; // R6
            else
                o_pad_out <= i_core_out; // R7 R20
        end
    end

    // Count of consecutive TMS-high edges, saturating
    always_ff @(posedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            ones_cnt_reg <= 3'h0;
        else if (!i_tms)
            ones_cnt_reg <= 3'h0;
        else if (ones_cnt_reg != 3'(TMS_RESET_EDGES))
            ones_cnt_reg <= ones_cnt_reg + 3'h1;
    end

    AST_TMS_FIVE_RESET: assert property ( // R3
        @(posedge i_tck) disable iff (!i_trst_n)
        ones_cnt_reg == 3'(TMS_RESET_EDGES) |-> state_reg == ST_RESET)
        else $error("five TMS-high edges did not reach reset");

    AST_SEL_IR_BRANCH: assert property ( // R9
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_SEL_IR |=> state_reg == ($past(i_tms) ? ST_RESET : ST_CAP_IR))
        else $error("wrong branch from select-IR");

    AST_CAPIR_PATTERN: assert property ( // R10
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_CAP_IR |=> ir_shift_reg[1:0] == 2'b01)
        else $error("instruction capture pattern wrong");

    AST_SHIFTIR_MOVE: assert property ( // R11
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_SHIFT_IR |=>
            ir_shift_reg == {$past(i_tdi), $past(ir_shift_reg[IR_W-1:1])})
        else $error("instruction shift wrong");

    AST_PAUSEIR_HOLD: assert property ( // R12
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_PAUSE_IR && !i_tms |=> $stable(ir_shift_reg))
        else $error("instruction bits lost in pause");

    AST_RESET_IDCODE: assert property ( // R7
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_RESET |-> ir_active_reg == IR_IDCODE)
        else $error("reset state without identification instruction");

    AST_BYPASS_CLEAR: assert property ( // R19
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_CAP_DR && dr_sel == DR_BYPASS |=> bypass_reg == 1'b0)
        else $error("bypass stage not cleared");

    AST_ID_CAPTURE: assert property ( // R22
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_CAP_DR && dr_sel == DR_IDENT |=> id_shift_reg == ID_VALUE)
        else $error("identification capture wrong");

    AST_TDO_ENABLE: assert property ( // R25
        @(posedge i_tck) disable iff (!i_trst_n)
        $past(i_trst_n) |->
            o_tdo_oe == (state_reg == ST_SHIFT_IR || state_reg == ST_SHIFT_DR))
        else $error("data out enable outside shift states");

    COV_IR_UPDATE: cover property (
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_SHIFT_IR ##1 state_reg == ST_EXIT1_IR ##1 state_reg == ST_UPD_IR);

    COV_ID_SCAN: cover property (
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_SHIFT_DR && dr_sel == DR_IDENT);

    COV_HIGHZ: cover property (
        @(posedge i_tck) disable iff (!i_trst_n)
        ir_active_reg == IR_HIGHZ && state_reg == ST_SHIFT_DR);

    COV_TMS_RESET: cover property (
        @(posedge i_tck) disable iff (!i_trst_n)
        state_reg == ST_SEL_IR && i_tms ##1 state_reg == ST_RESET);

endmodule

// ### tb/jt_ctl_model.sv
// Boundary-scan controller model that drives the test port pins.
// Assumes the bench calls one task at a time; the test clock idles low.
`timescale 1ns/1ps
module jt_ctl_model (
    // Test port drive
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_trst_n,
    // Test port return
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe
);
    logic all_oe;

    // Idle levels, reset pin released
    initial
    begin
        o_tck    = 1'b0;
        o_tms    = 1'b1;
        o_tdi    = 1'b0;
        o_trst_n = 1'b1;
        all_oe   = 1'b0;
    end

    // Reset pulse given before any use of the device
    task automatic pulse_trst();
    begin
        #13;
        o_trst_n = 1'b0;
        #60;
        o_trst_n = 1'b1;
        #60;
    end
    endtask

    // One test clock period; output sampled before the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
    begin
        #1.3;
        o_tms = tms;
        o_tdi = tdi;
        #14.7;
        tdo    = i_tdo_oe ? i_tdo : ~i_tdo;   // Released pin reads as junk
        all_oe = all_oe & i_tdo_oe;
        o_tck  = 1'b1;
        #16;
        o_tck  = 1'b0;
        o_tdi  = ~tdi;   // No stale level once the bit is taken
    end
    endtask

    // Shift n bits LSB first, leaving the shift state on the last one
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
    begin
        dout   = '0;
        all_oe = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
    end
    endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the test access port.
// Assumes the controller model drives the test pins; pads are bench-driven.
`timescale 1ns/1ps
module tb;
    import jt_pkg::*;

    localparam logic [3:0]  IDV = 4'h6;      // Arbitrary value
    localparam logic [15:0] IDP = 16'h9c5e;  // Arbitrary value
    localparam logic [10:0] IDM = 11'h1d3;   // Arbitrary value
    localparam logic [31:0] IDW = {IDV, IDP, IDM, 1'b1};

    logic       clk;
    logic       i_reset;
    logic       tck;
    logic       tms;
    logic       tdi;
    logic       trst_n;
    logic       tdo;
    logic       tdo_oe;
    logic [7:0] core_out;
    logic [7:0] pad_in;
    logic [7:0] pad_out;
    logic       pad_oe;
    logic       test_active;
    int         num_errors;
    int         comparisons;
    logic [31:0] d;
    logic [3:0]  cap;

    // System clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    jt_ctl_model jm (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
                     .i_tdo(tdo), .i_tdo_oe(tdo_oe));

    jt_tap #(.PADS(8), .ID_VER(IDV), .ID_PART(IDP), .ID_MFR(IDM)) uut (
        .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_ref_clk(clk), .i_reset(i_reset),
        .i_core_out(core_out), .i_pad_in(pad_in), .o_pad_out(pad_out),
        .o_pad_oe(pad_oe), .o_test_active(test_active));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t value %h, expected %h", $time, got, exp);
        end
    end
    endtask

    // Walk n mode-select bits, LSB first
    task automatic walk(input logic [7:0] t, input int n);
        logic b;
    begin
        for (int i = 0; i < n; i++)
            jm.step(t[i], 1'b0, b);
    end
    endtask

    // Let crossing levels settle on the system side
    task automatic wref();
    begin
        repeat (24) @(negedge clk);
    end
    endtask

    // Instruction scan from Run-Test-Idle back to Run-Test-Idle
    task automatic ir(input logic [3:0] code, output logic [3:0] c);
        logic [31:0] o;
    begin
        walk(8'h03, 4);
        jm.shift(4, {28'h0, code}, o);
        c = o[3:0];
        chk(jm.all_oe, 1'b1);
        walk(8'h01, 2);
        chk(tdo_oe, 1'b0);
    end
    endtask

    // Data scan from Run-Test-Idle back to Run-Test-Idle
    task automatic dr(input int n, input logic [31:0] din, output logic [31:0] o);
    begin
        walk(8'h01, 3);
        jm.shift(n, din, o);
        walk(8'h01, 2);
    end
    endtask

    // Reset pin, idle levels, identification read after reset
    task automatic t_idcode();
    begin
        jm.pulse_trst();
        wref();
        chk(test_active, 1'b0);
        chk(pad_oe, 1'b1);
        walk(8'h00, 1);
        dr(32, 32'h0, d);
        chk(d, IDW);
        chk(test_active, 1'b1);
    end
    endtask

    // Capture pattern and one-stage bypass for bypass, unknown, high-z
    task automatic t_bypass();
        logic [3:0] codes [3];
    begin
        codes = '{IR_BYPASS, 4'h7, IR_HIGHZ};
        for (int k = 0; k < 3; k++)
        begin
            ir(codes[k], cap);
            chk(cap, 4'h1);
            dr(4, 32'hb, d);
            chk(d, 32'h6);
        end
        wref();
        chk(pad_oe, 1'b0);
        chk(pad_out, 8'h5a);
    end
    endtask

    // Pause in mid instruction scan keeps the shifted bits
    task automatic t_pause();
        logic [31:0] o;
    begin
        walk(8'h03, 4);
        jm.shift(2, 32'h2, o);
        chk(o, 32'h1);
        walk(8'h04, 4);
        jm.shift(4, 32'h2, o);
        chk(o, 32'h8);
        walk(8'h01, 2);
        dr(32, 32'h0, d);
        chk(d, IDW);
        wref();
        chk(pad_oe, 1'b1);
    end
    endtask

    // Five mode-select highs from Shift-DR, not four, reach reset
    task automatic t_tms_reset();
    begin
        ir(IR_BYPASS, cap);
        walk(8'h01, 3);
        walk(8'h0f, 4);
        wref();
        chk(test_active, 1'b1);
        walk(8'h01, 1);
        wref();
        chk(test_active, 1'b0);
        walk(8'h00, 1);
        dr(32, 32'h0, d);
        chk(d, IDW);
    end
    endtask

    // Sample captures pads and preloads; extest then drives the word
    task automatic t_extest();
    begin
        ir(IR_SAMPLE, cap);
        dr(8, 32'ha5, d);
        chk(d, 32'h3c);
        wref();
        chk(pad_out, 8'h5a);
        ir(IR_EXTEST, cap);
        wref();
        chk(pad_out, 8'ha5);
        chk(pad_oe, 1'b1);
    end
    endtask

    // Verdict and end of run
    task automatic final_report();
    begin
        $display("Mismatches %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // Main sequence
    initial
    begin
        num_errors  = 0;
        comparisons = 0;
        i_reset     = 1'b1;
        core_out    = 8'h5a;
        pad_in      = 8'h3c;
        repeat (3) @(negedge clk);
        i_reset = 1'b0;
        t_idcode();
        t_bypass();
        t_pause();
        t_tms_reset();
        t_extest();
        final_report();
    end

    // Watchdog
    initial
    begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule
